// ===== design/dav_pkg.sv
// Shared constants and types for the delta angle and velocity outputs
package dav_pkg;

	// System clock and internal sample clock timing
	localparam int CLK_PERIOD_NS    = 10;
	localparam int SAMPLE_RATE_SPS  = 2000;
	localparam int SAMPLE_PERIOD_NS = 1_000_000_000 / SAMPLE_RATE_SPS;
	localparam int SAMPLE_DIV       = SAMPLE_PERIOD_NS / CLK_PERIOD_NS;

	// Byte addresses of the output registers, words on even addresses
	localparam logic [6:0] ADDR_Y_ANG_LOW  = 7'h28;
	localparam logic [6:0] ADDR_Y_ANG_HIGH = 7'h2A;
	localparam logic [6:0] ADDR_Z_ANG_LOW  = 7'h2C;
	localparam logic [6:0] ADDR_Z_ANG_HIGH = 7'h2E;
	localparam logic [6:0] ADDR_X_VEL_LOW  = 7'h30;
	localparam logic [6:0] ADDR_X_VEL_HIGH = 7'h32;

	// Field layout of a 32-bit result split into two words
	localparam int WORD_W    = 16;
	localparam int HIGH_LSB  = 16;
	localparam int RESULT_W  = 32;

	// Reset and idle values
	localparam logic [15:0] RDATA_UNMAPPED = 16'h0000;
	localparam logic [31:0] RESULT_RESET   = 32'h0000_0000;
	localparam logic [15:0] DEC_RESET      = 16'h0000;

	// Saturation limits of the 32-bit result
	localparam logic signed [31:0] SAT_POS = 32'sh7FFF_FFFF;
	localparam logic signed [31:0] SAT_NEG = 32'sh8000_0000;

	// Scaling: angle gain is the base over the model full scale
	localparam int ANGLE_FS_DEG  = 2160;
	localparam int ANG_GAIN_BASE = 4320;
	localparam int VEL_GAIN      = 1;
	localparam int OUT_SHIFT     = 12;

	// Sequencing of one sample step
	typedef enum logic [1:0] {
		DAV_WAIT,
		DAV_ACCUM,
		DAV_PUBLISH
	} dav_phase_e;

endpackage : dav_pkg

// ===== design/dav_trap_integ.sv
// Trapezoidal integrator for one axis with 32-bit saturating result
`timescale 1ns/1ps
module dav_trap_integ #(
	parameter int SAMPLE_W = 16,
	parameter int ACC_W    = 40,
	parameter int GAIN     = 1,
	parameter int SHIFT    = 12
) (
	input  wire logic                clk_sys,     // System clock
	input  wire logic                srst,        // Sync reset, high
	input  wire logic                sampleEn,    // Take one sample
	input  wire logic                lastEn,      // Sample ends period
	input  wire logic [SAMPLE_W-1:0] sample,      // Signed rate sample
	output logic      [31:0]         result,      // Saturated result
	output logic                     resultValid  // Result loaded pulse
);
	localparam int PROD_W = ACC_W + 16;

	typedef struct packed {
		logic [SAMPLE_W-1:0] prev;
		logic [ACC_W-1:0]    acc;
		logic [31:0]         result;
		logic                valid;
	} dav_integ_s;

	dav_integ_s st, next_st;
	logic signed [ACC_W-1:0]  sum;
	logic signed [PROD_W-1:0] prod;
	logic signed [PROD_W-1:0] scaled;

	// Sum of current and previous sample, scaled then clipped
	always_comb begin
		next_st = st;
		next_st.valid = 1'b0;
		sum = $signed(st.acc) + ACC_W'($signed(sample)) // see R06
			+ ACC_W'($signed(st.prev));
		prod = PROD_W'(sum) * PROD_W'(GAIN);
		scaled = prod >>> SHIFT;
		if (sampleEn) begin
			next_st.prev = sample; // Carries across periods
			next_st.acc = sum;
			if (lastEn) begin
				next_st.acc = '0;
				next_st.valid = 1'b1;
				if (scaled > PROD_W'(dav_pkg::SAT_POS)) begin
					next_st.result = dav_pkg::SAT_POS; // see R04
				end else if (scaled < PROD_W'(dav_pkg::SAT_NEG)) begin
					next_st.result = dav_pkg::SAT_NEG; // see R04
				end else begin
					next_st.result = scaled[31:0];
				end
			end
		end
	end

	// State register
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign result = st.result;
	assign resultValid = st.valid;

	a_trap_sum: assert property (@(posedge clk_sys) disable iff (srst) // see R06
		sampleEn && !lastEn |=> st.acc == $past(sum))
		else $error("accumulator did not add sample pair");

	a_sat_pos: assert property (@(posedge clk_sys) disable iff (srst) // see R04
		sampleEn && lastEn && scaled > PROD_W'(dav_pkg::SAT_POS)
		|=> result == dav_pkg::SAT_POS && resultValid)
		else $error("positive overflow not clipped");

endmodule : dav_trap_integ

// ===== design/dav_outputs.sv
// Delta angle (y, z) and x delta velocity output registers
//
// Contract
// R01: Y angle low/high words at 0x28/0x2A
// R02: High word two's complement, LSB fullscale/2^15
// R03: Z angle words at 0x2C/0x2E, same format
// R04: Saturate; 32-bit LSB is fullscale/2^31
// R05: Output velocity change per output update
// R06: Sum sample plus predecessor, over 2fs
// R07: Samples per update equal decimation plus one
// R08: Internal sample clock runs at 2000 SPS
// R09: Host may rescale by measured ready rate
// R10: X velocity low word at 0x30, high 0x32
// R11: Velocity high word two's complement, 400 range
// R12: Angles use same trapezoid on gyro samples
// R13: Angle full scale set by model variant
// R14: Both words of a pair update together
`timescale 1ns/1ps
module dav_outputs #(
	parameter int SAMPLE_W     = 16,
	parameter int ACC_W        = 40,
	parameter int SAMPLE_DIV   = dav_pkg::SAMPLE_DIV,
	parameter int ANGLE_FS_DEG = dav_pkg::ANGLE_FS_DEG
) (
	input  wire logic                clk_sys,    // 100 MHz clock
	input  wire logic                srst,       // Sync reset, high
	input  wire logic [SAMPLE_W-1:0] gyroY,      // Y rate sample
	input  wire logic [SAMPLE_W-1:0] gyroZ,      // Z rate sample
	input  wire logic [SAMPLE_W-1:0] accelX,     // X accel sample
	input  wire logic [15:0]         decimationSetting, // Decimation
	input  wire logic                regRead,    // Read request pulse
	input  wire logic [6:0]          regAddr,    // Read byte address
	output logic      [15:0]         regRdata,   // Read data
	output logic                     regAck,     // Read data valid
	output logic                     sampleTake, // Sample taken pulse
	output logic                     dataUpdate  // Outputs loaded pulse
);
	localparam int DIV_W = $clog2(SAMPLE_DIV);
	localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(SAMPLE_DIV - 1);
	// Larger full scale means fewer counts per degree
	localparam int ANG_GAIN = dav_pkg::ANG_GAIN_BASE / ANGLE_FS_DEG;

	typedef struct packed {
		dav_pkg::dav_phase_e phase;
		logic [DIV_W-1:0]    divCnt;
		logic [15:0]         decCnt;
		logic [15:0]         decLatched;
		logic [31:0]         yAng;
		logic [31:0]         zAng;
		logic [31:0]         xVel;
		logic [15:0]         rdata;
		logic                ack;
		logic                take;
		logic                update;
	} dav_top_s;

	dav_top_s    st, next_st;
	logic        sampleEn;
	logic        lastEn;
	logic [31:0] yResult;
	logic [31:0] zResult;
	logic [31:0] xResult;
	logic        yValid;
	logic        zValid;
	logic        xValid;
	logic [6:0]  wordAddr;

	// Integrators run only in the accumulate step
	assign sampleEn = (st.phase == dav_pkg::DAV_ACCUM);
	assign lastEn = (st.decCnt == st.decLatched); // see R07
	assign wordAddr = {regAddr[6:1], 1'b0};

	// Gyro Y integrator, same trapezoid as velocity
	dav_trap_integ #( // see R12
		.SAMPLE_W (SAMPLE_W),
		.ACC_W    (ACC_W),
		.GAIN     (ANG_GAIN), // see R13
		.SHIFT    (dav_pkg::OUT_SHIFT)
	) u_int_y (
		.clk_sys     (clk_sys),
		.srst        (srst),
		.sampleEn    (sampleEn),
		.lastEn      (lastEn),
		.sample      (gyroY),
		.result      (yResult),
		.resultValid (yValid)
	);

	// Gyro Z integrator
	dav_trap_integ #( // see R12
		.SAMPLE_W (SAMPLE_W),
		.ACC_W    (ACC_W),
		.GAIN     (ANG_GAIN), // see R13
		.SHIFT    (dav_pkg::OUT_SHIFT)
	) u_int_z (
		.clk_sys     (clk_sys),
		.srst        (srst),
		.sampleEn    (sampleEn),
		.lastEn      (lastEn),
		.sample      (gyroZ),
		.result      (zResult),
		.resultValid (zValid)
	);

	// Accel X integrator gives the velocity change
	dav_trap_integ #( // see R05
		.SAMPLE_W (SAMPLE_W),
		.ACC_W    (ACC_W),
		.GAIN     (dav_pkg::VEL_GAIN), // see R11
		.SHIFT    (dav_pkg::OUT_SHIFT)
	) u_int_x (
		.clk_sys     (clk_sys),
		.srst        (srst),
		.sampleEn    (sampleEn),
		.lastEn      (lastEn),
		.sample      (accelX),
		.result      (xResult),
		.resultValid (xValid)
	);

	// Next-state logic: sample clock, decimation, publish, reads
	always_comb begin
		next_st = st;
		next_st.take = 1'b0;
		next_st.update = 1'b0;
		next_st.ack = 1'b0;

		// Free-running divider sets the sample rate
		if (st.divCnt == DIV_LAST) begin // see R08
			next_st.divCnt = '0;
		end else begin
			next_st.divCnt = st.divCnt + 1'b1;
		end

		case (st.phase)
			dav_pkg::DAV_WAIT: begin
				if (st.divCnt == DIV_LAST) begin // see R08
					next_st.phase = dav_pkg::DAV_ACCUM;
					next_st.take = 1'b1;
				end
			end
			dav_pkg::DAV_ACCUM: begin
				if (lastEn) begin // see R07
					next_st.decCnt = '0;
					next_st.phase = dav_pkg::DAV_PUBLISH;
				end else begin
					next_st.decCnt = st.decCnt + 1'b1;
					next_st.phase = dav_pkg::DAV_WAIT;
				end
			end
			dav_pkg::DAV_PUBLISH: begin
				// Whole 32-bit values load at once for coherent reads
				next_st.yAng = yResult; // see R14
				next_st.zAng = zResult; // see R14
				next_st.xVel = xResult; // see R14
				next_st.update = 1'b1;
				// New setting only at a period boundary
				next_st.decLatched = decimationSetting; // see R07
				next_st.phase = dav_pkg::DAV_WAIT;
			end
			default: begin
				next_st.phase = dav_pkg::DAV_WAIT;
			end
		endcase

		// Read port; both bytes of a word return the same word
		if (regRead) begin
			next_st.ack = 1'b1;
			if (wordAddr == dav_pkg::ADDR_Y_ANG_LOW) begin // see R01
				next_st.rdata = st.yAng[dav_pkg::WORD_W-1:0];
			end else if (wordAddr == dav_pkg::ADDR_Y_ANG_HIGH) begin
				next_st.rdata = st.yAng[31:dav_pkg::HIGH_LSB]; // see R02
			end else if (wordAddr == dav_pkg::ADDR_Z_ANG_LOW) begin
				next_st.rdata = st.zAng[dav_pkg::WORD_W-1:0]; // see R03
			end else if (wordAddr == dav_pkg::ADDR_Z_ANG_HIGH) begin
				next_st.rdata = st.zAng[31:dav_pkg::HIGH_LSB]; // see R03
			end else if (wordAddr == dav_pkg::ADDR_X_VEL_LOW) begin
				next_st.rdata = st.xVel[dav_pkg::WORD_W-1:0]; // see R10
			end else if (wordAddr == dav_pkg::ADDR_X_VEL_HIGH) begin
				next_st.rdata = st.xVel[31:dav_pkg::HIGH_LSB]; // see R11
			end else begin
				next_st.rdata = dav_pkg::RDATA_UNMAPPED;
			end
		end
	end

	// State register; outputs come straight from it
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			st <= '0;
			st.phase <= dav_pkg::DAV_WAIT;
			st.decLatched <= dav_pkg::DEC_RESET;
			st.yAng <= dav_pkg::RESULT_RESET;
			st.zAng <= dav_pkg::RESULT_RESET;
			st.xVel <= dav_pkg::RESULT_RESET;
			st.rdata <= dav_pkg::RDATA_UNMAPPED;
		end else begin
			st <= next_st;
		end
	end

	assign regRdata = st.rdata;
	assign regAck = st.ack;
	assign sampleTake = st.take;
	assign dataUpdate = st.update;

	// Helper: samples since the last publish, for checking only
	logic [16:0] chkSamples;
	logic [DIV_W-1:0] chkGap;
	logic             chkSeen;
	always_ff @(posedge clk_sys) begin
		if (srst || st.update) begin
			chkSamples <= '0;
		end else if (sampleEn) begin
			chkSamples <= chkSamples + 1'b1;
		end
	end
	always_ff @(posedge clk_sys) begin
		if (srst || st.take) begin
			chkGap <= '0;
		end else begin
			chkGap <= chkGap + 1'b1;
		end
	end
	// First gap after reset counts one more than DIV_LAST, so skip it
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			chkSeen <= 1'b0;
		end else if (st.take) begin
			chkSeen <= 1'b1;
		end
	end

	a_dec_count: assert property (@(posedge clk_sys) disable iff (srst) // see R07
		st.phase == dav_pkg::DAV_PUBLISH
		|-> chkSamples == 17'(st.decLatched) + 17'd1)
		else $error("period sample count differs from setting");

	a_tick_spacing: assert property (@(posedge clk_sys) disable iff (srst) // see R08
		st.take && chkSeen |-> chkGap == DIV_LAST)
		else $error("sample pulses not one sample period apart");

	a_pair_coherent: assert property (@(posedge clk_sys) disable iff (srst) // see R14
		yValid |=> dataUpdate && st.yAng == $past(yResult)
		&& st.zAng == $past(zResult) && st.xVel == $past(xResult))
		else $error("output pair not loaded from one update");

	a_read_yhigh: assert property (@(posedge clk_sys) disable iff (srst) // see R01
		regRead && wordAddr == dav_pkg::ADDR_Y_ANG_HIGH && !st.update
		|=> regAck && regRdata == $past(st.yAng[31:16]))
		else $error("y high word read wrong");

	a_read_xlow: assert property (@(posedge clk_sys) disable iff (srst) // see R10
		regRead && wordAddr == dav_pkg::ADDR_X_VEL_LOW && !st.update
		|=> regAck && regRdata == $past(st.xVel[15:0]))
		else $error("x velocity low word read wrong");

	a_read_ack: assert property (@(posedge clk_sys) disable iff (srst)
		regRead |=> regAck ##1 (regAck == $past(regRead)))
		else $error("read not answered in one cycle");

	a_update_after: assert property (@(posedge clk_sys) disable iff (srst) // see R05
		sampleEn && lastEn |=> !dataUpdate ##1 dataUpdate)
		else $error("update not two cycles after last sample");

	// Remaining words each come from their own 32-bit value
	a_read_ylow: assert property (@(posedge clk_sys) disable iff (srst) // see R01
		regRead && wordAddr == dav_pkg::ADDR_Y_ANG_LOW
		|=> regAck && regRdata == $past(st.yAng[15:0]))
		else $error("y low word read wrong");

	a_read_zlow: assert property (@(posedge clk_sys) disable iff (srst) // see R03
		regRead && wordAddr == dav_pkg::ADDR_Z_ANG_LOW
		|=> regAck && regRdata == $past(st.zAng[15:0]))
		else $error("z low word read wrong");

	a_read_zhigh: assert property (@(posedge clk_sys) disable iff (srst) // see R03
		regRead && wordAddr == dav_pkg::ADDR_Z_ANG_HIGH
		|=> regAck && regRdata == $past(st.zAng[31:16]))
		else $error("z high word read wrong");

	a_read_xhigh: assert property (@(posedge clk_sys) disable iff (srst) // see R11
		regRead && wordAddr == dav_pkg::ADDR_X_VEL_HIGH
		|=> regAck && regRdata == $past(st.xVel[31:16]))
		else $error("x velocity high word read wrong");

	a_read_none: assert property (@(posedge clk_sys) disable iff (srst) // see R01
		regRead && wordAddr != dav_pkg::ADDR_Y_ANG_LOW
		&& wordAddr != dav_pkg::ADDR_Y_ANG_HIGH
		&& wordAddr != dav_pkg::ADDR_Z_ANG_LOW
		&& wordAddr != dav_pkg::ADDR_Z_ANG_HIGH
		&& wordAddr != dav_pkg::ADDR_X_VEL_LOW
		&& wordAddr != dav_pkg::ADDR_X_VEL_HIGH
		|=> regAck && regRdata == dav_pkg::RDATA_UNMAPPED)
		else $error("unmapped word did not read zero");

	a_take_pulse: assert property (@(posedge clk_sys) disable iff (srst) // see R08
		sampleTake |=> !sampleTake)
		else $error("sample pulse longer than one cycle");

	a_upd_pulse: assert property (@(posedge clk_sys) disable iff (srst) // see R05
		dataUpdate |=> !dataUpdate)
		else $error("update pulse longer than one cycle");

	a_dec_latch: assert property (@(posedge clk_sys) disable iff (srst) // see R07
		dataUpdate |-> st.decLatched == $past(decimationSetting))
		else $error("decimation not latched at publish");

endmodule : dav_outputs

// ===== tb/dav_host_model.sv
// Host model that issues reads on the register read port
`timescale 1ns/1ps
module dav_host_model (
	input  wire logic        clk_sys,  // System clock
	input  wire logic        regAck,   // Read answer
	input  wire logic [15:0] regRdata, // Read data
	output logic             regRead,  // Read request
	output logic      [6:0]  regAddr   // Read byte address
);
	// Idle lines at time zero
	initial begin
		regRead = 1'b0;
		regAddr = 7'h7F;
	end

	// One read; the address is inverted after use so no stale value lingers
	task automatic readWord(input logic [6:0] addr, output logic [15:0] data,
		output bit ok);
		ok = 1'b0;
		data = 16'hxxxx;
		@(negedge clk_sys);
		regRead <= 1'b1;
		regAddr <= addr;
		@(negedge clk_sys);
		regRead <= 1'b0;
		regAddr <= ~addr;
		for (int i = 0; i < 4 && !ok; i++) begin
			if (regAck === 1'b1) begin
				data = regRdata;
				ok = 1'b1;
			end else begin
				@(negedge clk_sys);
			end
		end
	endtask : readWord
endmodule : dav_host_model

// ===== tb/testbench.sv
// Self-checking bench for the delta angle and velocity outputs
`timescale 1ns/1ps
`define CHK(got, exp) begin \
	checksDone++; \
	if ((got) !== (exp)) begin \
		errors++; \
		$display("wrong value at %0t: got %h want %h", $time, got, exp); \
	end \
end
module testbench;
	localparam int DIV = 8;
	localparam int AG  = dav_pkg::ANG_GAIN_BASE / dav_pkg::ANGLE_FS_DEG;
	// Cycles from a sample pulse to the update pulse of a period's last sample
	localparam int UPD_LAT = 2;
	logic        clk_sys;
	logic        srst;
	logic [15:0] gyroY;
	logic [15:0] gyroZ;
	logic [15:0] accelX;
	logic [15:0] decimationSetting;
	logic        regRead;
	logic [6:0]  regAddr;
	logic [15:0] regRdata;
	logic        regAck;
	logic        sampleTake;
	logic        dataUpdate;
	logic [15:0] rd;
	bit          ok;
	int          errors;
	int          checksDone;
	int          gap;

	// Short divider keeps the run small
	dav_outputs #(
		.SAMPLE_DIV   (DIV),
		.ANGLE_FS_DEG (dav_pkg::ANGLE_FS_DEG)
	) i_dut (
		.clk_sys(clk_sys), .srst(srst), .gyroY(gyroY), .gyroZ(gyroZ),
		.accelX(accelX), .decimationSetting(decimationSetting),
		.regRead(regRead), .regAddr(regAddr), .regRdata(regRdata),
		.regAck(regAck), .sampleTake(sampleTake), .dataUpdate(dataUpdate));
	dav_host_model i_host (.clk_sys(clk_sys), .regAck(regAck),
		.regRdata(regRdata), .regRead(regRead), .regAddr(regAddr));

	// Clock at 100 MHz
	initial clk_sys = 1'b0;
	always #5 clk_sys = ~clk_sys;

	// Expected result of n summed terms of a steady sample
	function automatic logic [31:0] trap(input logic signed [15:0] s,
		input int n, input int g);
		longint p;
		p = longint'(s) * n * g;
		return 32'(p >>> 12);
	endfunction : trap

	task automatic expWord(input logic [6:0] a, input logic [15:0] e);
		i_host.readWord(a, rd, ok);
		`CHK(ok, 1'b1)
		`CHK(rd, e)
	endtask : expWord

	// All six words for n steady terms
	task automatic expAll(input int n);
		logic [31:0] y;
		logic [31:0] z;
		logic [31:0] x;
		y = trap(gyroY, n, AG);
		z = trap(gyroZ, n, AG);
		x = trap(accelX, n, dav_pkg::VEL_GAIN);
		expWord(dav_pkg::ADDR_Y_ANG_LOW, y[15:0]);
		expWord(dav_pkg::ADDR_Y_ANG_HIGH, y[31:16]);
		expWord(dav_pkg::ADDR_Z_ANG_LOW, z[15:0]);
		expWord(dav_pkg::ADDR_Z_ANG_HIGH, z[31:16]);
		expWord(dav_pkg::ADDR_X_VEL_LOW, x[15:0]);
		expWord(dav_pkg::ADDR_X_VEL_HIGH, x[31:16]);
	endtask : expAll

	// Cycles until the next pulse, bounded so a silent design cannot hang
	task automatic waitPulse(input bit take, output int n);
		n = 0;
		do begin
			@(negedge clk_sys);
			n++;
		end while ((take ? sampleTake : dataUpdate) !== 1'b1 && n < 1000);
		`CHK(n < 1000, 1'b1)
	endtask : waitPulse

	task automatic wrap_up();
		$display("checks %0d mismatches %0d", checksDone, errors);
		if (errors == 0 && checksDone > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : wrap_up

	// Main sequence
	initial begin
		errors = 0;
		checksDone = 0;
		srst = 1'b1;
		gyroY = 16'h1000;
		gyroZ = 16'hF000;
		accelX = 16'h4000;
		decimationSetting = 16'h0000;
		repeat (12) @(negedge clk_sys);
		srst = 1'b0;
		// First update has a zero predecessor
		expWord(dav_pkg::ADDR_Y_ANG_LOW, 16'h0000);
		waitPulse(1'b0, gap);
		expWord(dav_pkg::ADDR_Y_ANG_LOW, 16'(trap(gyroY, 1, AG)));
		waitPulse(1'b1, gap);
		waitPulse(1'b1, gap);
		`CHK(gap, DIV)
		waitPulse(1'b0, gap);
		`CHK(gap, UPD_LAT)
		// Zero decimation: update spacing gives the sample rate
		waitPulse(1'b0, gap);
		`CHK(gap, DIV)
		expAll(2);
		expWord(7'h34, dav_pkg::RDATA_UNMAPPED);
		expWord(7'h2D, 16'(trap(gyroZ, 2, AG)));
		$display("test steady_rate done");
		// New decimation and a negative acceleration
		decimationSetting = 16'h0003;
		accelX = 16'hC000;
		repeat (3) waitPulse(1'b0, gap);
		`CHK(gap, 4 * DIV)
		expAll(8);
		$display("test decimation done");
		// Reset in mid-run clears the results
		srst = 1'b1;
		repeat (2) @(negedge clk_sys);
		srst = 1'b0;
		expWord(dav_pkg::ADDR_Y_ANG_HIGH, 16'h0000);
		expWord(dav_pkg::ADDR_X_VEL_LOW, 16'h0000);
		$display("test second_reset done");
		wrap_up();
	end

	// Watchdog over thirty times the expected run
	initial begin
		repeat (5000) @(posedge clk_sys);
		errors++;
		wrap_up();
	end
endmodule : testbench
